// >>> hdl/msrb_bank.sv
// msr bank: indirect apb access port, core-side fast_system_call, swap and timestamp paths
`timescale 1ns/10ps
// Functional notes
// - feature-enable register, cleared to zero on reset
// - legacy fast_system_call: target and selectors from legacy
// - long mode fast_system_call pointer from long target
// - compat mode fast_system_call pointer from compat target
// - f segment base register, reset zero
// - g segment base register, reset zero
// - base swap exchanges swap and g base
// - aux read copies aux; aux resets zero
// - guest timestamp scaled by ratio, reset one
// - fast entry code selector, legacy mode
// - fast entry stack pointer, legacy mode
// - fast entry instruction pointer, legacy mode
// - read-only range capability with fixed value
// - eight variable range base registers
module msrb_bank #(
    parameter int ADDR_W = 12   // apb address width
) (
    input  wire logic               clk,          // core clock, 25 MHz
    input  wire logic               rst_b,        // async reset, active low
    input  wire logic               psel,         // apb select
    input  wire logic               penable,      // apb access phase
    input  wire logic               pwrite,       // apb direction
    input  wire logic [ADDR_W-1:0]  paddr,        // apb byte address
    input  wire logic [31:0]        pwdata,       // apb write data
    input  wire logic [3:0]         pstrb,        // apb byte enables
    input  wire logic [2:0]         pprot,        // apb protection
    output logic      [31:0]        prdata_q,     // apb read data
    output logic                    pready_q,     // apb ready
    output logic                    pslverr_q,    // apb error
    input  wire logic [1:0]         cpu_mode,     // core execution mode
    input  wire logic               fast_system_call_req,  // fast system call pulse
    input  wire logic               entry_req,    // fast entry pulse
    input  wire logic               swap_req,     // base swap pulse
    input  wire logic               aux_req,      // timestamp read with aux
    input  wire logic [63:0]        time_stamp,   // timestamp counter
    output logic                    target_vld_q, // target fields updated
    output logic      [63:0]        target_ip_q,  // new instruction pointer
    output logic      [15:0]        target_cs_q,  // new code selector
    output logic      [15:0]        target_ss_q,  // new stack selector
    output logic      [63:0]        target_sp_q,  // new stack pointer
    output logic      [31:0]        count_gpr_q,  // aux value for count gpr
    output logic      [63:0]        guest_time_q, // scaled guest timestamp
    output logic      [63:0]        ext_feat_q,   // feature enables
    output logic      [63:0]        f_base_q,     // f segment base
    output logic      [63:0]        g_base_q      // g segment base
);
    import msrb_pkg::*;

    // the window decode needs five address bits
    if (ADDR_W < WIN_AW) begin : g_chk
        $error("msrb_bank: ADDR_W below 5");
    end

    logic [31:0] idx_q;               // selected msr index
    logic [31:0] dlo_q;               // staged data low
    logic [31:0] dhi_q;               // staged data high
    logic        fault_q;             // sticky access fault
    logic [63:0] bank [NREG];         // register contents
    logic [NREG-1:0] hit;             // index matches a slot
    logic [NREG-1:0] we;              // slot load strobes
    logic [63:0] ld_val [NREG];       // slot load values
    logic [63:0] rd_val;              // looked-up msr value

    // apb phase decode
    wire         setup    = psel & ~penable;
    wire         take     = psel & penable & pready_q;
    wire [WIN_AW-1:0] off = paddr[WIN_AW-1:0];
    // upper address bits must be clear, so aliases of the window are answered with an error
    wire         hi_zero  = (paddr >> WIN_AW) == '0;
    wire         sel_idx  = hi_zero && off == OFF_INDEX;
    wire         sel_dlo  = hi_zero && off == OFF_DLO;
    wire         sel_dhi  = hi_zero && off == OFF_DHI;
    wire         sel_cmd  = hi_zero && off == OFF_CMD;
    wire         sel_stat = hi_zero && off == OFF_STAT;
    wire         mapped   = sel_idx | sel_dlo | sel_dhi | sel_cmd | sel_stat;
    wire         priv     = pprot[PROT_PRIV];
    wire         wtake    = take & pwrite;
    // a command from unprivileged code is refused
    wire         cmd_go   = wtake & sel_cmd & priv;
    wire         cmd_bad  = wtake & sel_cmd & ~priv;
    wire         cmd_rd   = cmd_go & pwdata[CMD_RD_BIT];
    wire         cmd_wr   = cmd_go & pwdata[CMD_WR_BIT];
    wire         cap_hit  = idx_q == IDX_CAP;
    wire         any_hit  = |hit;
    // unknown index, or a write to the read-only capability, faults
    wire         flt_set  = cmd_bad | ((cmd_rd | cmd_wr) & ~any_hit & ~cap_hit)
                            | (cmd_wr & cap_hit);
    wire         flt_clr  = wtake & sel_stat & pwdata[STAT_FLT_BIT];
    wire         err_now  = ~mapped | (pwrite & sel_cmd & ~priv);
    wire [63:0]  stage    = {dhi_q, dlo_q};
    wire         do_swap  = swap_req;

    // index match per slot, and the bank itself
    for (genvar i = 0; i < NREG; i++) begin : g_slot
        assign hit[i] = idx_q == IDX_TAB[i];
        // the swap port owns the g base and swap slots in its cycle; a
        // software write landing in that same cycle on those slots is dropped
        if (i == SL_GBASE || i == SL_SWAP) begin : g_swp
            assign we[i]     = do_swap | (cmd_wr & hit[i]);
            assign ld_val[i] = !do_swap ? stage
                             : (i == SL_GBASE) ? bank[SL_SWAP] : bank[SL_GBASE];
        end else begin : g_sw
            assign we[i]     = cmd_wr & hit[i];
            assign ld_val[i] = stage;
        end
        msrb_reg64 #(
            .RST (RST_TAB[i])
        ) u_reg (
            .clk   (clk),
            .rst_b (rst_b),
            .we    (we[i]),
            .d     (ld_val[i]),
            .q_q   (bank[i])
        );
    end

    // read lookup; capability is a constant, never stored
    always_comb begin
        rd_val = cap_hit ? CAP_VAL : 64'h0;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_val = bank[i];
            end
        end
    end

    // access-port staging registers and sticky fault
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q   <= 32'h0;
            dlo_q   <= 32'h0;
            dhi_q   <= 32'h0;
            fault_q <= 1'b0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (wtake & sel_idx & pstrb[b]) idx_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                if (wtake & sel_dlo & pstrb[b]) dlo_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                if (wtake & sel_dhi & pstrb[b]) dhi_q[b*8 +: 8] <= pwdata[b*8 +: 8];
            end
            if (cmd_rd & (any_hit | cap_hit)) begin
                dlo_q <= rd_val[31:0];
                dhi_q <= rd_val[63:32];
            end
            // a new fault wins over a clear in the same cycle
            fault_q <= flt_set | (fault_q & ~flt_clr);
        end
    end

    // apb answer: ready in the first cycle of the access phase, data from setup
    // the access never stretches, so no wait-state counter is needed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & err_now;
            if (setup & ~pwrite) begin
                prdata_q <= sel_idx  ? idx_q
                          : sel_dlo  ? dlo_q
                          : sel_dhi  ? dhi_q
                          : sel_stat ? {31'h0, fault_q} : 32'h0;
            end
        end
    end

    // control transfer targets; mode picks the source register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            target_vld_q <= 1'b0;
            target_ip_q  <= 64'h0;
            target_cs_q  <= 16'h0;
            target_ss_q  <= 16'h0;
            target_sp_q  <= 64'h0;
        end else begin
            target_vld_q <= fast_system_call_req | entry_req;
            if (fast_system_call_req) begin
                case (cpu_mode)
                    MODE_LONG: begin
                        target_ip_q <= bank[SL_SCLONG];
                    end
                    MODE_COMPAT: begin
                        target_ip_q <= bank[SL_SCCMP];
                    end
                    default: begin
                        // legacy: 32-bit pointer and both selectors in one register
                        target_ip_q <= {32'h0, bank[SL_SCLEG][SCLEG_IP_HI:0]};
                        target_cs_q <= bank[SL_SCLEG][SCLEG_CS_LO +: 16];
                        target_ss_q <= bank[SL_SCLEG][SCLEG_CS_LO +: 16] + SS_STEP;
                    end
                endcase
            end else if (entry_req) begin
                target_cs_q <= bank[SL_FECS][15:0];
                target_sp_q <= bank[SL_FESP];
                target_ip_q <= {32'h0, bank[SL_FEIP][31:0]};
            end
        end
    end

    // timestamp paths; the scale multiply is one full cycle of logic
    // the full product is kept; the middle word drops fraction and overflow
    wire [RATIO_W+63:0] scaled = time_stamp * bank[SL_RATIO][RATIO_W-1:0];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_gpr_q  <= 32'h0;
            guest_time_q <= 64'h0;
        end else begin
            if (aux_req) count_gpr_q <= bank[SL_AUX][31:0];
            guest_time_q <= scaled[FRAC_W +: 64];
        end
    end

    // mirrors of the registers the core consumes directly
    // one cycle of latency is traded for outputs that all leave a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_feat_q <= 64'h0;
            f_base_q   <= 64'h0;
            g_base_q   <= 64'h0;
        end else begin
            ext_feat_q <= bank[SL_FEAT];
            f_base_q   <= bank[SL_FBASE];
            g_base_q   <= bank[SL_GBASE];
        end
    end

    // checks: each property watches what the bank itself drives; a write
    // to a mirrored slot shows on the mirror two edges after the command
    // is taken, once for the slot load and once for the mirror flop, so
    // those properties look back two samples for the staged value
    sequence s_sw_write(int s);
        cmd_wr && hit[s] && !do_swap;
    endsequence

    // feature enables reach the core through the mirror
    property p_feat_wr;
        @(posedge clk) disable iff (!rst_b)
        s_sw_write(SL_FEAT) |=> ##1 ext_feat_q == $past(stage, 2);
    endproperty
    a_feat_wr: assert property (p_feat_wr) else $error("feature enable not written");

    // legacy call takes pointer and code selector from one register
    property p_sc_legacy;
        @(posedge clk) disable iff (!rst_b)
        fast_system_call_req && cpu_mode == MODE_LEGACY |=>
            target_ip_q[31:0] == $past(bank[SL_SCLEG][31:0]) && target_vld_q
            && target_cs_q == $past(bank[SL_SCLEG][SCLEG_CS_LO +: 16]);
    endproperty
    a_sc_legacy: assert property (p_sc_legacy) else $error("legacy fast_system_call target wrong");

    // long mode takes the full pointer from the long target
    property p_sc_long;
        @(posedge clk) disable iff (!rst_b)
        fast_system_call_req && cpu_mode == MODE_LONG |=> target_ip_q == $past(bank[SL_SCLONG]);
    endproperty
    a_sc_long: assert property (p_sc_long) else $error("long fast_system_call target wrong");

    // compatibility mode takes the full pointer from the compat target
    property p_sc_compat;
        @(posedge clk) disable iff (!rst_b)
        fast_system_call_req && cpu_mode == MODE_COMPAT |=> target_ip_q == $past(bank[SL_SCCMP]);
    endproperty
    a_sc_compat: assert property (p_sc_compat) else $error("compat fast_system_call target wrong");

    // segment bases reach the core through their mirrors
    property p_fbase_wr;
        @(posedge clk) disable iff (!rst_b)
        s_sw_write(SL_FBASE) |=> ##1 f_base_q == $past(stage, 2);
    endproperty
    a_fbase_wr: assert property (p_fbase_wr) else $error("f base not written");

    property p_gbase_wr;
        @(posedge clk) disable iff (!rst_b)
        s_sw_write(SL_GBASE) |=> ##1 g_base_q == $past(stage, 2);
    endproperty
    a_gbase_wr: assert property (p_gbase_wr) else $error("g base not written");

    // both slots change at the same edge, never one after the other
    property p_swap;
        @(posedge clk) disable iff (!rst_b)
        do_swap |=> bank[SL_GBASE] == $past(bank[SL_SWAP]) && bank[SL_SWAP] == $past(bank[SL_GBASE]);
    endproperty
    a_swap: assert property (p_swap) else $error("base swap did not exchange");

    // only the low word fits the count register
    property p_aux;
        @(posedge clk) disable iff (!rst_b)
        aux_req |=> count_gpr_q == $past(bank[SL_AUX][31:0]);
    endproperty
    a_aux: assert property (p_aux) else $error("aux value not copied");

    // a unit ratio must pass the count through untouched
    property p_scale;
        @(posedge clk) disable iff (!rst_b)
        $stable(bank[SL_RATIO]) && bank[SL_RATIO] == RST_TAB[SL_RATIO]
            |=> guest_time_q == $past(time_stamp);
    endproperty
    a_scale: assert property (p_scale) else $error("unit ratio changed timestamp");

    // fast entry fills selector, stack and pointer together
    property p_entry;
        @(posedge clk) disable iff (!rst_b)
        entry_req && !fast_system_call_req |=> target_cs_q == $past(bank[SL_FECS][15:0])
            && target_sp_q == $past(bank[SL_FESP]) && target_ip_q[31:0] == $past(bank[SL_FEIP][31:0]);
    endproperty
    a_entry: assert property (p_entry) else $error("fast entry target wrong");

    // the capability has no storage, so a write can only fault
    property p_cap_ro;
        @(posedge clk) disable iff (!rst_b)
        cmd_wr && cap_hit |=> fault_q;
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capability write not faulted");

    // an unknown index faults and leaves the staging untouched
    property p_unknown;
        @(posedge clk) disable iff (!rst_b)
        (cmd_rd || cmd_wr) && !any_hit && !cap_hit |=> fault_q && $stable(dlo_q);
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown index not faulted");

    // an unprivileged command is answered with an error and a fault
    property p_unpriv;
        @(posedge clk) disable iff (!rst_b)
        setup && pwrite && sel_cmd && !priv |=> pslverr_q && pready_q ##1 fault_q;
    endproperty
    a_unpriv: assert property (p_unpriv) else $error("unprivileged command accepted");

    // a read command of a stored slot lands in the staging pair
    property p_rd_stage;
        @(posedge clk) disable iff (!rst_b)
        cmd_rd && any_hit |=> stage == $past(rd_val);
    endproperty
    a_rd_stage: assert property (p_rd_stage) else $error("read command not staged");

    // the fault flag stays up until software clears it
    property p_flt_hold;
        @(posedge clk) disable iff (!rst_b)
        fault_q && !flt_clr |=> fault_q;
    endproperty
    a_flt_hold: assert property (p_flt_hold) else $error("fault flag dropped");
endmodule : msrb_bank

// >>> hdl/msrb_pkg.sv
// package: register indices, reset values and field positions of the msr bank
package msrb_pkg;
    // apb window offsets (byte addresses of the indirect access port)
    localparam logic [4:0]  OFF_INDEX = 5'h00;   // msr index to act on
    localparam logic [4:0]  OFF_DLO   = 5'h04;   // data bits 31:0
    localparam logic [4:0]  OFF_DHI   = 5'h08;   // data bits 63:32
    localparam logic [4:0]  OFF_CMD   = 5'h0c;   // command strobe
    localparam logic [4:0]  OFF_STAT  = 5'h10;   // status, fault flag
    localparam int          CMD_RD_BIT   = 0;    // command: read msr
    localparam int          CMD_WR_BIT   = 1;    // command: write msr
    localparam int          STAT_FLT_BIT = 0;    // status: access fault
    localparam int          PROT_PRIV    = 0;    // pprot bit for privileged
    localparam int          WIN_AW       = 5;    // address bits the window decodes
    // msr indices as printed
    localparam logic [31:0] IDX_CAP   = 32'h0000_00fe;
    localparam int          NREG      = 22;
    localparam int          SL_FEAT   = 0;
    localparam int          SL_SCLEG  = 1;
    localparam int          SL_SCLONG = 2;
    localparam int          SL_SCCMP  = 3;
    localparam int          SL_FBASE  = 5;
    localparam int          SL_GBASE  = 6;
    localparam int          SL_SWAP   = 7;
    localparam int          SL_AUX    = 8;
    localparam int          SL_RATIO  = 9;
    localparam int          SL_FECS   = 10;
    localparam int          SL_FESP   = 11;
    localparam int          SL_FEIP   = 12;
    localparam logic [31:0] IDX_TAB [NREG] = '{
        32'hc000_0080, 32'hc000_0081, 32'hc000_0082, 32'hc000_0083,
        32'hc000_0084, 32'hc000_0100, 32'hc000_0101, 32'hc000_0102,
        32'hc000_0103, 32'hc000_0104, 32'h0000_0174, 32'h0000_0175,
        32'h0000_0176, 32'h0000_001b, 32'h0000_0200, 32'h0000_0202,
        32'h0000_0204, 32'h0000_0206, 32'h0000_0208, 32'h0000_020a,
        32'h0000_020c, 32'h0000_020e};
    // reset values; undefined ones, and the unknown nibble of the irq base, are given zero
    localparam logic [63:0] RST_TAB [NREG] = '{
        64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0,
        64'h0, 64'h0000_0001_0000_0000, 64'h0, 64'h0, 64'h0, 64'h0000_0000_fee0_0000,
        64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0};
    localparam logic [63:0] CAP_VAL   = 64'h0000_0000_0000_0508;
    // execution modes seen by the core
    localparam logic [1:0]  MODE_LEGACY = 2'h0;
    localparam logic [1:0]  MODE_LONG   = 2'h1;
    localparam logic [1:0]  MODE_COMPAT = 2'h2;
    // legacy fast_system_call target fields
    localparam int          SCLEG_IP_HI = 31;
    localparam int          SCLEG_CS_LO = 32;
    localparam logic [15:0] SS_STEP    = 16'h0008;
    // guest timestamp scale: integer in 39:32, fraction in 31:0
    localparam int          RATIO_W    = 40;
    localparam int          FRAC_W     = 32;
endpackage : msrb_pkg

// >>> hdl/msrb_reg64.sv
// one 64-bit model-specific register with a load strobe
`timescale 1ns/10ps
module msrb_reg64 #(
    parameter logic [63:0] RST = 64'h0   // value after reset
) (
    input  wire logic        clk,   // core clock
    input  wire logic        rst_b, // async reset, active low
    input  wire logic        we,    // load strobe
    input  wire logic [63:0] d,     // value to load
    output logic      [63:0] q_q    // stored value
);
    // plain storage; all loads arrive through we
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q_q <= RST;
        end else if (we) begin
            q_q <= d;
        end
    end
endmodule : msrb_reg64

// >>> verification/tb_msrb_bank.sv
// self-checking bench for the msr bank: apb window, reset values and core paths
`timescale 1ns/10ps
module tb_msrb_bank;
    import msrb_pkg::*;
    logic        clk;          // core clock, 40 ns
    logic        rst_b;        // reset, active low
    logic        psel;         // apb select
    logic        penable;      // apb access phase
    logic        pwrite;       // apb direction
    logic [11:0] paddr;        // apb byte address
    logic [31:0] pwdata;       // apb write data
    logic [2:0]  pprot;        // apb protection
    logic [1:0]  cpu_mode;     // core execution mode
    logic [3:0]  req;          // fast_system_call, entry, swap, aux pulses
    logic [63:0] time_stamp;   // timestamp counter
    logic [31:0] prdata_q;     // apb read data
    logic        pready_q;     // apb ready
    logic        pslverr_q;    // apb error
    logic        target_vld_q; // target update pulse
    logic [63:0] target_ip_q;  // new instruction pointer
    logic [15:0] target_cs_q;  // new code selector
    logic [15:0] target_ss_q;  // new stack selector
    logic [63:0] target_sp_q;  // new stack pointer
    logic [31:0] count_gpr_q;  // aux copy
    logic [63:0] guest_time_q; // scaled timestamp
    logic [63:0] ext_feat_q;   // feature enables
    logic [63:0] f_base_q;     // f segment base
    logic [63:0] g_base_q;     // g segment base
    int          err_count;    // mismatches seen
    int          comparisons;  // comparisons made
    int          cycles = 0;   // timeout counter

    msrb_bank #(.ADDR_W(12)) uut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pprot(pprot), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .cpu_mode(cpu_mode), .fast_system_call_req(req[0]),
        .entry_req(req[1]), .swap_req(req[2]), .aux_req(req[3]), .time_stamp(time_stamp),
        .target_vld_q(target_vld_q), .target_ip_q(target_ip_q), .target_cs_q(target_cs_q),
        .target_ss_q(target_ss_q), .target_sp_q(target_sp_q), .count_gpr_q(count_gpr_q),
        .guest_time_q(guest_time_q), .ext_feat_q(ext_feat_q), .f_base_q(f_base_q), .g_base_q(g_base_q));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard: far above the ~1030 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [2:0] prot,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {7'h0, a};
        pwdata  <= wd;
        pprot   <= prot;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count is assumed; the hang guard ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        err = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, 3'h1, r, e);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, 3'h1, d, e);
    endtask : rd

    // a 64-bit msr goes as index, low word, high word, then write command
    task automatic msr_wr(input logic [31:0] idx, input logic [63:0] v);
        wr(OFF_INDEX, idx);
        wr(OFF_DLO, v[31:0]);
        wr(OFF_DHI, v[63:32]);
        wr(OFF_CMD, 32'h2);
    endtask : msr_wr

    task automatic msr_rd(input logic [31:0] idx, output logic [63:0] v);
        wr(OFF_INDEX, idx);
        wr(OFF_CMD, 32'h1);
        rd(OFF_DLO, v[31:0]);
        rd(OFF_DHI, v[63:32]);
    endtask : msr_rd

    // fault flag must be set, then is cleared by writing one
    task automatic fault_seen;
        logic [31:0] s;
        rd(OFF_STAT, s);
        check({32'h0, s}, 64'h1);
        wr(OFF_STAT, 32'h1);
        rd(OFF_STAT, s);
        check({32'h0, s}, 64'h0);
    endtask : fault_seen

    // one-cycle core pulse in the given mode; returns just after the answer edge
    task automatic pulse(input int b, input logic [1:0] m);
        @(posedge clk);
        cpu_mode <= m;
        req      <= 4'(1 << b);
        @(posedge clk);
        req <= 4'h0;
        #1;
    endtask : pulse

    // main sequence
    initial begin
        logic [63:0] v;
        logic [31:0] r;
        logic        e;
        {psel, penable, pwrite, paddr, pwdata, pprot, req} = '0;
        {cpu_mode, err_count, comparisons} = '0;
        time_stamp = 64'h1234;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(guest_time_q, 64'h1234);
        // reset contents, ratio one, irq base fee00000 and the rest zero
        for (int i = 0; i < NREG; i++) begin
            msr_rd(IDX_TAB[i], v);
            check(v, (IDX_TAB[i] == 32'hc000_0104) ? 64'h1_0000_0000
                   : (IDX_TAB[i] == 32'h0000_001b) ? 64'hfee0_0000 : 64'h0);
        end
        msr_rd(32'h0000_00fe, v);
        check(v, 64'h508);
        // every writable msr takes a distinct pattern back-to-back
        for (int i = 0; i < NREG; i++) msr_wr(IDX_TAB[i], {IDX_TAB[i], ~IDX_TAB[i]});
        for (int i = 0; i < NREG; i++) begin
            msr_rd(IDX_TAB[i], v);
            check(v, {IDX_TAB[i], ~IDX_TAB[i]});
        end
        check(ext_feat_q, {32'hc000_0080, ~32'hc000_0080});
        check(f_base_q, {32'hc000_0100, ~32'hc000_0100});
        check(g_base_q, {32'hc000_0101, ~32'hc000_0101});
        // capability is read-only, unknown index and unprivileged command fault
        msr_wr(32'h0000_00fe, 64'hffff);
        fault_seen();
        msr_rd(32'h0000_00fe, v);
        check(v, 64'h508);
        msr_wr(32'h0000_0201, 64'h1);
        fault_seen();
        wr(OFF_INDEX, 32'hc000_0080);
        apb(1'b1, OFF_CMD, 32'h2, 3'h0, r, e);
        check({63'h0, e}, 64'h1);
        fault_seen();
        check(ext_feat_q, {32'hc000_0080, ~32'hc000_0080});
        apb(1'b0, 5'h14, 32'h0, 3'h1, r, e);
        check({r, 31'h0, e}, 64'h1);
        // guest timestamp scaled by 2.5
        msr_wr(32'hc000_0104, 64'h2_8000_0000);
        time_stamp <= 64'h100;
        repeat (3) @(posedge clk);
        #1;
        check(guest_time_q, 64'h280);
        // fast system call in each mode
        msr_wr(32'hc000_0081, 64'h0023_0010_8765_4321);
        msr_wr(32'hc000_0082, 64'hffff_8000_1234_5678);
        msr_wr(32'hc000_0083, 64'h1111_2222_3333_4444);
        pulse(0, MODE_LEGACY);
        check({target_vld_q, target_cs_q, target_ss_q}, {1'b1, 16'h0010, 16'h0018});
        check(target_ip_q, 64'h8765_4321);
        @(posedge clk);
        #1;
        check({63'h0, target_vld_q}, 64'h0);
        pulse(0, MODE_LONG);
        check(target_ip_q, 64'hffff_8000_1234_5678);
        pulse(0, MODE_COMPAT);
        check(target_ip_q, 64'h1111_2222_3333_4444);
        // fast entry in legacy mode
        msr_wr(32'h0000_0174, 64'hdead_0000_0000_0063);
        msr_wr(32'h0000_0175, 64'h0000_0000_7fff_fff0);
        msr_wr(32'h0000_0176, 64'h5555_6666_c010_2030);
        pulse(1, MODE_LEGACY);
        check({target_vld_q, target_cs_q}, {1'b1, 16'h0063});
        check(target_sp_q, 64'h7fff_fff0);
        check(target_ip_q, 64'hc010_2030);
        // base swap exchanges g base and swap base
        msr_wr(32'hc000_0101, 64'haaaa_0000_0000_1111);
        msr_wr(32'hc000_0102, 64'hbbbb_0000_0000_2222);
        pulse(2, MODE_LONG);
        @(posedge clk);
        #1;
        check(g_base_q, 64'hbbbb_0000_0000_2222);
        msr_rd(32'hc000_0102, v);
        check(v, 64'haaaa_0000_0000_1111);
        // timestamp read with aux copies the low word
        msr_wr(32'hc000_0103, 64'h9abc_def0_1357_2468);
        pulse(3, MODE_LONG);
        check({32'h0, count_gpr_q}, 64'h1357_2468);
        final_report();
    end
endmodule : tb_msrb_bank
